//--- logic/tcw_defines.vh
// Register map, field positions, reset values and timing masks of the timer
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define TCW_ADDR_CNT_L   8'h84
`define TCW_ADDR_CNT_H   8'h85
`define TCW_ADDR_TOPR_L  8'h86
`define TCW_ADDR_TOPR_H  8'h87
`define TCW_ADDR_CMPA_L  8'h88
`define TCW_ADDR_CMPA_H  8'h89
`define TCW_ADDR_CMPB_L  8'h8a
`define TCW_ADDR_CMPB_H  8'h8b
`define TCW_ADDR_CTRL_A  8'h90
`define TCW_ADDR_CTRL_B  8'h91
`define TCW_ADDR_FORCE   8'h92

// ****************************************
// Reset values and writable masks
// ****************************************
`define TCW_CTRL_A_RST   8'h00
`define TCW_CTRL_B_RST   8'h00
`define TCW_WORD_RST     16'h0000
`define TCW_CTRL_A_MASK  8'hf3
`define TCW_CTRL_B_MASK  8'hdf

// ****************************************
// Field positions
// ****************************************
`define TCW_OMA_HI       7
`define TCW_OMA_LO       6
`define TCW_OMB_HI       5
`define TCW_OMB_LO       4
`define TCW_WGML_HI      1
`define TCW_WGML_LO      0
`define TCW_WGMH_HI      4
`define TCW_WGMH_LO      3
`define TCW_CS_HI        2
`define TCW_CS_LO        0
`define TCW_FORCE_A      7
`define TCW_FORCE_B      6

// ****************************************
// Waveform classes and compare update points
// ****************************************
`define TCW_CLS_PLAIN    2'h0
`define TCW_CLS_FAST     2'h1
`define TCW_CLS_PHASE    2'h2
`define TCW_UPD_NOW      2'h0
`define TCW_UPD_TOP      2'h1
`define TCW_UPD_BOT      2'h2

// ****************************************
// Prescaler terminal masks
// ****************************************
`define TCW_DIV8_MASK    10'h007
`define TCW_DIV64_MASK   10'h03f
`define TCW_DIV256_MASK  10'h0ff
`define TCW_DIV1024_MASK 10'h3ff

`endif

//--- logic/tcw_prescaler.v
// Clock select and prescaler producing the counter tick
`timescale 1ns/10ps
`default_nettype none
`include "tcw_defines.vh"

module tcw_prescaler (
  input  wire       clk,
  input  wire       rst,
  input  wire [2:0] sel,
  output reg        tick
);

  reg [9:0] pre_q;

  always @(posedge clk) begin
    if (rst) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // Select 0 and the external-clock codes stop the counter
  always @* begin
    case (sel)
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_q & `TCW_DIV8_MASK) == `TCW_DIV8_MASK;
      3'h3:    tick = (pre_q & `TCW_DIV64_MASK) == `TCW_DIV64_MASK;
      3'h4:    tick = (pre_q & `TCW_DIV256_MASK) == `TCW_DIV256_MASK;
      3'h5:    tick = pre_q == `TCW_DIV1024_MASK;
      default: tick = 1'b0;
    endcase
  end

endmodule // tcw_prescaler

`default_nettype wire

//--- logic/tcw_wave_out.v
// One compare output: waveform level and pin takeover
`timescale 1ns/10ps
`default_nettype none
`include "tcw_defines.vh"

module tcw_wave_out (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] out_mode,
  input  wire [1:0] cls,
  input  wire       tog_ok,
  input  wire       match,
  input  wire       force_cmp,
  input  wire       bottom,
  input  wire       down,
  input  wire       top_eq,
  output reg        wave_q,
  output reg        ovr_q
);

  reg wave_d;
  reg ovr_d;
  reg hit;

  always @* begin
    wave_d = wave_q;
    ovr_d  = out_mode != 2'h0;
    hit    = match;
    case (cls)
      `TCW_CLS_FAST: begin
        // Compare at TOP is dropped in out modes 10 and 11; BOTTOM action still happens
        if (top_eq && out_mode[1]) hit = 1'b0; // [R12]
        if (out_mode == 2'h1) begin
          ovr_d = tog_ok; // [R09]
          if (tog_ok && hit) wave_d = ~wave_q; // [R09]
        end else if (out_mode == 2'h2) begin
          if (hit) wave_d = 1'b0; // [R10]
          else if (bottom) wave_d = 1'b1; // [R10]
        end else if (out_mode == 2'h3) begin
          if (hit) wave_d = 1'b1; // [R11]
          else if (bottom) wave_d = 1'b0; // [R11]
        end
      end
      `TCW_CLS_PHASE: begin
        if (out_mode == 2'h1) begin
          ovr_d = tog_ok; // [R13]
          if (tog_ok && hit) wave_d = ~wave_q; // [R13]
        end else if (out_mode == 2'h2) begin
          if (hit) wave_d = down; // [R14]
        end else if (out_mode == 2'h3) begin
          if (hit) wave_d = ~down; // [R15]
        end
      end
      default: begin
        // Forced compare acts only in the plain modes
        if (hit || force_cmp) begin
          case (out_mode)
            2'h1:    wave_d = ~wave_q; // [R08]
            2'h2:    wave_d = 1'b0; // [R08]
            2'h3:    wave_d = 1'b1; // [R08]
            default: wave_d = wave_q;
          endcase
        end
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      wave_q <= 1'b0;
      ovr_q  <= 1'b0;
    end else begin
      wave_q <= wave_d;
      ovr_q  <= ovr_d;
    end
  end

endmodule // tcw_wave_out

`default_nettype wire

//--- logic/tcw_timer.v
// Sixteen-bit timer with two compare channels and waveform outputs
//
// Functional notes
// [R01] Each compare value is checked against the counter on every tick.
// [R02] Wide writes latch the high byte first in one shared temp register.
// [R03] Control A: out mode A 7:6, out mode B 5:4, mode low 1:0.
// [R04] Nonzero out mode A hands the A pin to the waveform.
// [R05] Nonzero out mode B hands the B pin to the waveform.
// [R06] Software sets the pin direction bit to see the waveform.
// [R07] Software sets the port data bit for the B outputs too.
// [R08] Plain modes: 01 toggles, 10 clears, 11 sets on match.
// [R09] Fast PWM 01: A toggles in modes 14, 15; else disconnected.
// [R10] Fast PWM 10: clear on match, set at BOTTOM.
// [R11] Fast PWM 11: set on match, clear at BOTTOM.
// [R12] Fast PWM: compare equal to TOP with high bit ignores match.
// [R13] Phase PWM 01: A toggles in modes 9, 11; else disconnected.
// [R14] Phase PWM 10: clear on up-count match, set on down-count.
// [R15] Phase PWM 11: set on up-count match, clear on down-count.
// [R16] Four mode bits choose counting, TOP source and waveform type.
// [R17] Normal, clear-on-match, fast, phase and phase-frequency modes.
// [R18] A counter write blocks compare matches on the next tick.
// [R19] Clock select 0 stops; 1 to 5 divide by 1, 8, 64, 256, 1024.
// [R20] Control A bits 3:2 read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "tcw_defines.vh"

module tcw_timer (
  input  wire       SYS_CLK,
  input  wire       RST,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  output wire       WAVE_OUT_A,
  output wire       WAVE_OUT_B,
  output wire       WAVE_OVR_A,
  output wire       WAVE_OVR_B,
  output wire       MATCH_A,
  output wire       MATCH_B
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  temp_q;
  reg  [15:0] cnt_q;
  reg  [15:0] topr_q;
  reg  [7:0]  ctrl_a_q;
  reg  [7:0]  ctrl_b_q;
  reg         down_q;
  reg         block_q;

  wire [31:0] cmp_buf_w;
  wire [31:0] cmp_act_w;
  wire [1:0]  wave_w;
  wire [1:0]  ovr_w;
  wire [1:0]  match_w;
  wire        tick;

  wire [3:0]  wgm = {ctrl_b_q[`TCW_WGMH_HI:`TCW_WGMH_LO],
                     ctrl_a_q[`TCW_WGML_HI:`TCW_WGML_LO]};
  wire [15:0] wide_w = {temp_q, WDATA}; // [R02]
  wire        wr_cnt = WR && (ADDR == `TCW_ADDR_CNT_L);

  // ****************************************
  // Mode decode
  // ****************************************
  reg  [15:0] top_w;
  reg  [1:0]  cls_w;
  reg  [1:0]  upd_w;
  reg         tog_w;

  always @* begin
    top_w = 16'hffff;
    cls_w = `TCW_CLS_PLAIN;
    upd_w = `TCW_UPD_NOW;
    tog_w = 1'b0;
    case (wgm) // [R16]
      4'h0: top_w = 16'hffff; // [R17]
      4'h1: begin
        top_w = 16'h00ff;
        cls_w = `TCW_CLS_PHASE;
        upd_w = `TCW_UPD_TOP;
      end
      4'h2: begin
        top_w = 16'h01ff;
        cls_w = `TCW_CLS_PHASE;
        upd_w = `TCW_UPD_TOP;
      end
      4'h3: begin
        top_w = 16'h03ff;
        cls_w = `TCW_CLS_PHASE;
        upd_w = `TCW_UPD_TOP;
      end
      4'h4: top_w = cmp_act_w[15:0]; // [R17]
      4'h5: begin
        top_w = 16'h00ff;
        cls_w = `TCW_CLS_FAST;
        upd_w = `TCW_UPD_BOT;
      end
      4'h6: begin
        top_w = 16'h01ff;
        cls_w = `TCW_CLS_FAST;
        upd_w = `TCW_UPD_BOT;
      end
      4'h7: begin
        top_w = 16'h03ff;
        cls_w = `TCW_CLS_FAST;
        upd_w = `TCW_UPD_BOT;
      end
      4'h8, 4'h9: begin
        top_w = wgm[0] ? cmp_act_w[15:0] : topr_q;
        cls_w = `TCW_CLS_PHASE;
        upd_w = `TCW_UPD_BOT;
        tog_w = wgm[0]; // [R13]
      end
      4'ha, 4'hb: begin
        top_w = wgm[0] ? cmp_act_w[15:0] : topr_q;
        cls_w = `TCW_CLS_PHASE;
        upd_w = `TCW_UPD_TOP;
        tog_w = wgm[0]; // [R13]
      end
      4'hc: top_w = topr_q; // [R17]
      4'he, 4'hf: begin
        top_w = wgm[0] ? cmp_act_w[15:0] : topr_q;
        cls_w = `TCW_CLS_FAST;
        upd_w = `TCW_UPD_BOT;
        tog_w = 1'b1; // [R09]
      end
      default: top_w = 16'hffff;
    endcase
  end

  // ****************************************
  // Counter
  // ****************************************
  tcw_prescaler u_pre (
    .clk  (SYS_CLK),
    .rst  (RST),
    .sel  (ctrl_b_q[`TCW_CS_HI:`TCW_CS_LO]),
    .tick (tick)
  ); // [R19]

  wire at_top = cnt_q == top_w;
  wire phase  = cls_w == `TCW_CLS_PHASE;
  wire bot_w  = tick && at_top && (cls_w == `TCW_CLS_FAST);
  wire low_w  = tick && down_q && (cnt_q == 16'h0001);
  wire upd_go = (upd_w == `TCW_UPD_NOW) ||
                ((upd_w == `TCW_UPD_TOP) && tick && at_top) ||
                ((upd_w == `TCW_UPD_BOT) && (bot_w || low_w));

  always @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_q   <= `TCW_WORD_RST;
      down_q  <= 1'b0;
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      cnt_q   <= wide_w; // [R02]
      block_q <= 1'b1; // [R18]
    end else if (tick) begin
      block_q <= 1'b0; // [R18]
      if (!phase) begin
        down_q <= 1'b0;
        cnt_q  <= at_top ? 16'h0000 : cnt_q + 16'h0001;
      end else if (!down_q) begin
        if (cnt_q >= top_w) begin
          down_q <= 1'b1;
          cnt_q  <= (top_w == 16'h0000) ? 16'h0000 : top_w - 16'h0001;
        end else begin
          cnt_q  <= cnt_q + 16'h0001;
        end
      end else if (cnt_q == 16'h0000) begin
        down_q <= 1'b0;
        cnt_q  <= (top_w == 16'h0000) ? 16'h0000 : 16'h0001;
      end else begin
        cnt_q  <= cnt_q - 16'h0001;
      end
    end
  end

  // ****************************************
  // Control, TOP register and shared temp
  // ****************************************
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_a_q <= `TCW_CTRL_A_RST;
      ctrl_b_q <= `TCW_CTRL_B_RST;
      topr_q   <= `TCW_WORD_RST;
      temp_q   <= 8'h00;
    end else begin
      if (WR && ADDR == `TCW_ADDR_CTRL_A)
        ctrl_a_q <= WDATA & `TCW_CTRL_A_MASK; // [R03] [R20]
      if (WR && ADDR == `TCW_ADDR_CTRL_B)
        ctrl_b_q <= WDATA & `TCW_CTRL_B_MASK; // [R16]
      if (WR && ADDR == `TCW_ADDR_TOPR_L)
        topr_q <= wide_w; // [R02]
      // One temp serves every wide register
      if (WR && ADDR[0] && ADDR >= `TCW_ADDR_CNT_H &&
          ADDR <= `TCW_ADDR_CMPB_H)
        temp_q <= WDATA; // [R02]
      else if (RD && ADDR == `TCW_ADDR_CNT_L)
        temp_q <= cnt_q[15:8];
      else if (RD && ADDR == `TCW_ADDR_TOPR_L)
        temp_q <= topr_q[15:8];
    end
  end

  // ****************************************
  // Compare channels
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : ch
      reg  [15:0] buf_q;
      reg  [15:0] act_q;
      reg         hit_q;
      wire [7:0]  adr_l = (i == 0) ? `TCW_ADDR_CMPA_L : `TCW_ADDR_CMPB_L;
      wire [1:0]  om    = (i == 0) ?
                          ctrl_a_q[`TCW_OMA_HI:`TCW_OMA_LO] :
                          ctrl_a_q[`TCW_OMB_HI:`TCW_OMB_LO];
      wire        fbit  = (i == 0) ? WDATA[`TCW_FORCE_A] :
                                     WDATA[`TCW_FORCE_B];
      wire        frc   = WR && (ADDR == `TCW_ADDR_FORCE) && fbit;
      wire        hit   = tick && !block_q && (cnt_q == act_q); // [R01]

      always @(posedge SYS_CLK) begin
        if (RST) begin
          buf_q <= `TCW_WORD_RST;
          act_q <= `TCW_WORD_RST;
          hit_q <= 1'b0;
        end else begin
          if (WR && ADDR == adr_l)
            buf_q <= wide_w; // [R02]
          if (upd_go)
            act_q <= buf_q;
          hit_q <= hit; // [R01] [R18]
        end
      end

      tcw_wave_out u_wave (
        .clk       (SYS_CLK),
        .rst       (RST),
        .out_mode  (om),
        .cls       (cls_w),
        .tog_ok    (tog_w && (i == 0)),
        .match     (hit),
        .force_cmp (frc),
        .bottom    (bot_w),
        .down      (down_q),
        .top_eq    (act_q == top_w),
        .wave_q    (wave_w[i]),
        .ovr_q     (ovr_w[i])
      ); // [R04] [R05]

      assign cmp_buf_w[16*i+15:16*i] = buf_q;
      assign cmp_act_w[16*i+15:16*i] = act_q;
      assign match_w[i] = hit_q;
    end
  endgenerate

  assign WAVE_OUT_A = wave_w[0];
  assign WAVE_OUT_B = wave_w[1];
  assign WAVE_OVR_A = ovr_w[0]; // [R04]
  assign WAVE_OVR_B = ovr_w[1]; // [R05]
  assign MATCH_A    = match_w[0];
  assign MATCH_B    = match_w[1];

  // ****************************************
  // Read port
  // ****************************************
  always @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `TCW_ADDR_CNT_L:  RDATA <= cnt_q[7:0];
        `TCW_ADDR_CNT_H:  RDATA <= temp_q;
        `TCW_ADDR_TOPR_L: RDATA <= topr_q[7:0];
        `TCW_ADDR_TOPR_H: RDATA <= temp_q;
        `TCW_ADDR_CMPA_L: RDATA <= cmp_buf_w[7:0];
        `TCW_ADDR_CMPA_H: RDATA <= cmp_buf_w[15:8];
        `TCW_ADDR_CMPB_L: RDATA <= cmp_buf_w[23:16];
        `TCW_ADDR_CMPB_H: RDATA <= cmp_buf_w[31:24];
        `TCW_ADDR_CTRL_A: RDATA <= ctrl_a_q; // [R20]
        `TCW_ADDR_CTRL_B: RDATA <= ctrl_b_q;
        default:          RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule // tcw_timer

`default_nettype wire

//--- tb/tcw_pin_load.sv
// External load on one compare output pin, pulled up when undriven
`timescale 1ns/10ps
`default_nettype none
module tcw_pin_load #(
  parameter bit NEED_PORT = 1'b0
) (
  input  wire logic wave,
  input  wire logic ovr,
  input  wire logic dir,
  input  wire logic port_bit,
  output wire logic pin
);
  wire drv_en = dir && (!NEED_PORT || port_bit);
  assign pin = drv_en ? (ovr ? wave : port_bit) : 1'b1;
endmodule // tcw_pin_load
`default_nettype wire

//--- tb/tcw_timer_assertions.sv
// Checker for bus reads, pin takeover and compare output actions
`timescale 1ns/10ps
`default_nettype none
module tcw_timer_checker (
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       WAVE_OUT_A,
  input wire logic       WAVE_OUT_B,
  input wire logic       WAVE_OVR_A,
  input wire logic       WAVE_OVR_B,
  input wire logic       MATCH_A,
  input wire logic       MATCH_B
);
  logic [7:0] ca_q;
  logic [7:0] cb_q;
  wire  [3:0] mode  = {cb_q[4:3], ca_q[1:0]};
  wire        plain = (mode[1:0] == 2'h0 && mode != 4'h8) || mode == 4'hd;
  wire  [1:0] oma   = ca_q[7:6];
  wire  [1:0] omb   = ca_q[5:4];
  // Shadow of both control registers, taken from the bus
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ca_q <= 8'h00;
      cb_q <= 8'h00;
    end else if (WR && ADDR == 8'h90) begin
      ca_q <= WDATA;
    end else if (WR && ADDR == 8'h91) begin
      cb_q <= WDATA;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence rd_ctl_s;
    RD && ADDR == 8'h90;
  endsequence
  ctl_read_a: assert property (rd_ctl_s |=> RDATA == ($past(ca_q) & 8'hf3))
    else $error("control A read back wrong");
  ovr_need_a: assert property (WAVE_OVR_A |-> oma != 0 || $past(oma) != 0)
    else $error("pin A taken with out mode zero");
  ovr_take_a: assert property ((plain && omb != 0)[*2] |-> WAVE_OVR_B)
    else $error("pin B not taken");
  stop_quiet_a: assert property ((cb_q[2:0] == 3'h0)[*4] |-> !MATCH_A && !MATCH_B)
    else $error("match while stopped");
  tog_plain_a: assert property (plain && oma == 1 && MATCH_A |-> WAVE_OUT_A != $past(WAVE_OUT_A))
    else $error("no toggle on match");
  clr_plain_a: assert property (plain && omb == 2 && MATCH_B |-> !WAVE_OUT_B)
    else $error("no clear on match");
  set_plain_a: assert property (plain && omb == 3 && MATCH_B |-> WAVE_OUT_B)
    else $error("no set on match");
  b_pwm_off_a: assert property ((!plain && omb == 1)[*2] |-> !WAVE_OVR_B)
    else $error("pin B taken in toggle PWM");
endmodule // tcw_timer_checker
bind tcw_timer tcw_timer_checker tcw_timer_checker_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B),
  .WAVE_OVR_A(WAVE_OVR_A), .WAVE_OVR_B(WAVE_OVR_B), .MATCH_A(MATCH_A),
  .MATCH_B(MATCH_B));
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the timer's compare outputs
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic       SYS_CLK, RST, WR, RD, dir_a, dir_b, port_data_bit_d2, ew;
  logic [7:0] ADDR, WDATA, RDATA, d, c;
  wire        WAVE_OUT_A, WAVE_OUT_B, WAVE_OVR_A, WAVE_OVR_B;
  wire        MATCH_A, MATCH_B, pin_a, pin_b;
  int         failures, n_compared, cycles, t, na, nb, nm;
  logic [1:0] pm [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
  int         dv [4] = '{0, 1, 8, 64};
  logic [7:0] wb [3] = '{8'h09, 8'h09, 8'h01};
  logic [7:0] wc [3] = '{8'h40, 8'hff, 8'h40};
  int         wp [3] = '{256, 256, 510};
  int         wa [3] = '{65, 256, 128};
  int         wn [3] = '{191, 0, 382};
  int         wt [3] = '{1, 0, 2};
  logic [7:0] oa [5] = '{8'h51, 8'h53, 8'h51, 8'h53, 8'h50};
  logic [7:0] ob [5] = '{8'h09, 8'h19, 8'h01, 8'h11, 8'h01};
  tcw_timer tcw_timer_i (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAVE_OUT_A(WAVE_OUT_A),
    .WAVE_OUT_B(WAVE_OUT_B), .WAVE_OVR_A(WAVE_OVR_A),
    .WAVE_OVR_B(WAVE_OVR_B), .MATCH_A(MATCH_A), .MATCH_B(MATCH_B));
  tcw_pin_load #(.NEED_PORT(1'b0)) load_a_i (.wave(WAVE_OUT_A),
    .ovr(WAVE_OVR_A), .dir(dir_a), .port_bit(port_data_bit_d2), .pin(pin_a));
  tcw_pin_load #(.NEED_PORT(1'b1)) load_b_i (.wave(WAVE_OUT_B),
    .ovr(WAVE_OVR_B), .dir(dir_b), .port_bit(port_data_bit_d2), .pin(pin_b));
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    `CHK("RDATA", e, d)
    @(posedge SYS_CLK);
  endtask
  // Stop, load both compares in a plain mode, then start from zero
  task automatic arm(input logic [7:0] ca, input logic [7:0] cb,
                     input logic [7:0] cv);
    wr(8'h91, 8'h00);
    wr(8'h90, 8'h00);
    wr16(8'h88, {8'h00, cv});
    wr16(8'h8a, {8'h00, cv});
    wr(8'h90, ca);
    wr16(8'h84, 16'h0000);
    wr(8'h91, cb);
  endtask
  task automatic wait_match(input int lim);
    t = 0;
    do begin
      @(posedge SYS_CLK);
      #1 t++;
    end while (MATCH_A !== 1'b1 && t < lim);
  endtask
  task automatic count(input int n);
    {na, nb, nm} = '0;
    repeat (n) begin
      @(posedge SYS_CLK);
      #1 na += int'(WAVE_OUT_A === 1'b1);
      nb += int'(WAVE_OUT_B === 1'b1);
      nm += int'(MATCH_A === 1'b1);
    end
  endtask
  // Plain-mode action of one out mode on a match or a forced compare
  function automatic logic act_plain(input logic [1:0] om, input logic w);
    return (om == 2'h1) ? ~w : (om == 2'h0) ? w : om[0];
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {WR, RD, dir_a, dir_b, port_data_bit_d2, ew} = '0;
    {ADDR, WDATA} = '0;
    {failures, n_compared, cycles} = '0;
    RST = 1'b1;
    c = 8'($urandom(32'h7005));
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    rdc(8'h90, 8'h00);
    rdc(8'h91, 8'h00);
    repeat (4) begin
      c = 8'($urandom);
      wr(8'h90, c);
      rdc(8'h90, c & 8'hf3);
    end
    wr(8'h8b, 8'h5a);
    wr(8'h88, 8'h3c);
    rdc(8'h88, 8'h3c);
    rdc(8'h89, 8'h5a);
    rdc(8'h8b, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      arm({pm[i], pm[i], 4'h0}, 8'h01, 8'(4 + $urandom % 60));
      wait_match(300);
      ew = act_plain(pm[i], ew);
      `CHK("MATCH_A", 1'b1, MATCH_A)
      `CHK("WAVE_OUT_A", ew, WAVE_OUT_A)
      `CHK("WAVE_OUT_B", ew, WAVE_OUT_B)
    end
    dir_a <= 1'b1;
    dir_b <= 1'b1;
    @(posedge SYS_CLK);
    #1 `CHK("pin_a", 1'b0, pin_a)
    `CHK("pin_b", 1'b1, pin_b)
    port_data_bit_d2 <= 1'b1;
    @(posedge SYS_CLK);
    #1 `CHK("pin_b", ew, pin_b)
    // Forced compare on A only, counter stopped
    wr(8'h91, 8'h00);
    wr(8'h90, 8'h50);
    wr(8'h92, 8'h80);
    #1 `CHK("WAVE_OUT_A", act_plain(2'h1, ew), WAVE_OUT_A)
    `CHK("WAVE_OUT_B", ew, WAVE_OUT_B)
    rdc(8'h92, 8'h00);
    $display("test plain modes done");
    for (int s = 0; s < 4; s++) begin
      arm(8'h40, 8'(s), 8'h04);
      wait_match(400);
      `CHK("tick span", 1'b1, s == 0 ? t == 400 : t >= dv[s] * 4 - 2 &&
           t <= dv[s] * 5 + 4)
    end
    arm(8'h40, 8'h01, 8'h30);
    repeat (8) @(posedge SYS_CLK);
    wr(8'h85, 8'h00);
    ADDR  <= 8'h84;
    WDATA <= 8'h30;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    count(40);
    `CHK("blocked match", 0, nm)
    $display("test counting done");
    for (int k = 0; k < 3; k++) begin
      arm(8'hb1, wb[k], wc[k]);
      repeat (600) @(posedge SYS_CLK);
      count(wp[k]);
      `CHK("high A", 1'b1, na + wt[k] >= wa[k] && na <= wa[k] + wt[k])
      `CHK("high B", 1'b1, nb + wt[k] >= wn[k] && nb <= wn[k] + wt[k])
    end
    for (int k = 0; k < 5; k++) begin
      arm(oa[k], ob[k], 8'h40);
      repeat (4) @(posedge SYS_CLK);
      #1 `CHK("WAVE_OVR_A", 1'((5'b11010 >> k) & 1), WAVE_OVR_A)
      `CHK("WAVE_OVR_B", 1'(k == 4), WAVE_OVR_B)
    end
    $display("test pwm modes done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
